// file: rtl/cmgic_top.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module cmgic_top #(
    parameter int ZC_TIMEOUT = cmgic_pkg::ZC_TIMEOUT_FRAMES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic signed [cmgic_pkg::SAMPLE_W-1:0] adc_left_i,
    input wire logic signed [cmgic_pkg::SAMPLE_W-1:0] adc_right_i,
    input wire logic sample_strobe_i,
    input wire logic left_zero_cross_i,
    input wire logic right_zero_cross_i,
    input wire logic pll_unlock_i,
    input wire logic adc_overrange_i,
    output cmgic_pkg::cmgic_chan_t [5:0] chan_o,
    output logic [2:0] pair_volume_link_o,
    output logic signed [cmgic_pkg::LEVEL_W-1:0] left_gain_level_o,
    output logic signed [cmgic_pkg::LEVEL_W-1:0] right_gain_level_o,
    output logic port_phase_align_o,
    output logic [1:0] deemph_select_o,
    output logic forced_lock_o,
    output logic irq_pin_o,
    output logic irq_pin_oe_o
);
    localparam logic [7:0] A_INVERT = {cmgic_pkg::IDX_INVERT, 2'h0};
    localparam logic [7:0] A_MIX1 = {cmgic_pkg::IDX_MIX1, 2'h0};
    localparam logic [7:0] A_MIX2 = {cmgic_pkg::IDX_MIX2, 2'h0};
    localparam logic [7:0] A_MIX3 = {cmgic_pkg::IDX_MIX3, 2'h0};
    localparam logic [7:0] A_XCTL = {cmgic_pkg::IDX_XCTL, 2'h0};
    localparam logic [7:0] A_LGAIN = {cmgic_pkg::IDX_LGAIN, 2'h0};
    localparam logic [7:0] A_RGAIN = {cmgic_pkg::IDX_RGAIN, 2'h0};
    localparam logic [7:0] A_IRQCTL = {cmgic_pkg::IDX_IRQCTL, 2'h0};
    localparam logic [7:0] A_FLAGS = {cmgic_pkg::IDX_FLAGS, 2'h0};
    localparam logic [7:0] A_MASK = {cmgic_pkg::IDX_MASK, 2'h0};
    localparam logic [7:0] A_MODE_MSB = {cmgic_pkg::IDX_MODE_MSB, 2'h0};
    localparam logic [7:0] A_MODE_LSB = {cmgic_pkg::IDX_MODE_LSB, 2'h0};

    cmgic_pkg::cmgic_bus_st_t bus_st_reg;
    logic [5:0] invert_reg;
    logic [2:0] link_reg;
    logic [4:0] mix_code_reg [3];
    logic [1:0] ramp_sel_reg;
    logic forced_lock_reg;
    logic signed [cmgic_pkg::GAIN_W-1:0] lgain_reg;
    logic signed [cmgic_pkg::GAIN_W-1:0] rgain_reg;
    cmgic_pkg::cmgic_irqctl_t irqctl_reg;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] mask_reg;
    logic [7:0] mode_msb_reg;
    logic [7:0] mode_lsb_reg;
    logic [7:0] snap_reg;
    logic [7:0] cond_prev_reg;
    logic [1:0] unlock_sync_reg;
    logic [1:0] over_sync_reg;
    logic [7:0] cond;
    logic [7:0] evt;
    logic [31:0] rd_val;
    logic wr_fire;
    logic rd_done;
    logic [7:0] wbyte;
    logic irq_active;
    cmgic_pkg::cmgic_src_t src_c [6];
    logic signed [cmgic_pkg::SAMPLE_W-1:0] smp_c [6];
    logic signed [cmgic_pkg::SAMPLE_W:0] lr_sum;

    // One wait cycle: request seen in IDLE, answered with waitrequest low in ACK
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            bus_st_reg <= cmgic_pkg::ST_IDLE;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            case (bus_st_reg)
                cmgic_pkg::ST_IDLE:
                begin
                    if (avs_read_i || avs_write_i)
                    begin
                        bus_st_reg <= cmgic_pkg::ST_ACK;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                default:
                begin
                    bus_st_reg <= cmgic_pkg::ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    assign wr_fire = (bus_st_reg == cmgic_pkg::ST_ACK) && avs_write_i && avs_byteenable_i[0];
    assign rd_done = (bus_st_reg == cmgic_pkg::ST_ACK) && avs_read_i && (avs_address_i == A_FLAGS);
    assign wbyte = avs_writedata_i[7:0];

    // Read mux; unused and reserved bits read zero
    always_comb
    begin
        rd_val = 32'h0;
        if (avs_address_i == A_INVERT)
            rd_val[5:0] = invert_reg;
        else if (avs_address_i == A_MIX1)
            rd_val[7:0] = {link_reg[0], 2'h0, mix_code_reg[0]};
        else if (avs_address_i == A_MIX2)
            rd_val[7:0] = {link_reg[1], 2'h0, mix_code_reg[1]};
        else if (avs_address_i == A_MIX3)
            rd_val[7:0] = {link_reg[2], 2'h0, mix_code_reg[2]};
        else if (avs_address_i == A_XCTL)
            rd_val[7:0] = {2'h0, ramp_sel_reg, 3'h0, forced_lock_reg};
        else if (avs_address_i == A_LGAIN)
            rd_val[5:0] = lgain_reg;
        else if (avs_address_i == A_RGAIN)
            rd_val[5:0] = rgain_reg;
        else if (avs_address_i == A_IRQCTL)
            rd_val[7:0] = {irqctl_reg.align, 1'b0, irqctl_reg.deemph, irqctl_reg.style, 2'h0};
        else if (avs_address_i == A_FLAGS)
            rd_val[7:0] = flags_reg & mask_reg;
        else if (avs_address_i == A_MASK)
            rd_val[7:0] = mask_reg;
        else if (avs_address_i == A_MODE_MSB)
            rd_val[7:0] = mode_msb_reg;
        else if (avs_address_i == A_MODE_LSB)
            rd_val[7:0] = mode_lsb_reg;
    end

    // Snapshot of returned flags so only reported events are cleared
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            avs_readdata_o <= 32'h0;
            snap_reg <= 8'h00;
        end
        else if (bus_st_reg == cmgic_pkg::ST_IDLE && avs_read_i)
        begin
            avs_readdata_o <= rd_val;
            snap_reg <= rd_val[7:0];
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            invert_reg <= '0;
            link_reg <= '0;
            mix_code_reg <= '{default: cmgic_pkg::MIX_CODE_RST};
            ramp_sel_reg <= '0;
            forced_lock_reg <= 1'b0;
            lgain_reg <= '0;
            rgain_reg <= '0;
            irqctl_reg <= '0;
            mask_reg <= cmgic_pkg::REG_RST;
            mode_msb_reg <= cmgic_pkg::REG_RST;
            mode_lsb_reg <= cmgic_pkg::REG_RST;
        end
        else if (wr_fire)
        begin
            if (avs_address_i == A_INVERT)
                invert_reg <= wbyte[5:0];
            else if (avs_address_i == A_MIX1)
                {link_reg[0], mix_code_reg[0]} <= {wbyte[cmgic_pkg::MIX_LINK_BIT], wbyte[4:0]};
            else if (avs_address_i == A_MIX2)
                {link_reg[1], mix_code_reg[1]} <= {wbyte[cmgic_pkg::MIX_LINK_BIT], wbyte[4:0]};
            else if (avs_address_i == A_MIX3)
                {link_reg[2], mix_code_reg[2]} <= {wbyte[cmgic_pkg::MIX_LINK_BIT], wbyte[4:0]};
            else if (avs_address_i == A_XCTL)
            begin
                ramp_sel_reg <= wbyte[cmgic_pkg::XCTL_RAMP_LSB +: 2];
                forced_lock_reg <= wbyte[cmgic_pkg::XCTL_LOCK_BIT];
            end
            else if (avs_address_i == A_LGAIN)
                lgain_reg <= wbyte[5:0];
            else if (avs_address_i == A_RGAIN)
                rgain_reg <= wbyte[5:0];
            else if (avs_address_i == A_IRQCTL)
            begin
                irqctl_reg.align <= wbyte[cmgic_pkg::CTL_ALIGN_BIT];
                irqctl_reg.deemph <= wbyte[cmgic_pkg::CTL_DEEMPH_LSB +: 2];
                irqctl_reg.style <= wbyte[cmgic_pkg::CTL_STYLE_LSB +: 2];
            end
            else if (avs_address_i == A_MASK)
                mask_reg <= wbyte & cmgic_pkg::FLAG_USED;
            else if (avs_address_i == A_MODE_MSB)
                mode_msb_reg <= wbyte & cmgic_pkg::FLAG_USED;
            else if (avs_address_i == A_MODE_LSB)
                mode_lsb_reg <= wbyte & cmgic_pkg::FLAG_USED;
        end
    end

    // Pin inputs pass two flops; only the second stage is read
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            unlock_sync_reg <= 2'h0;
            over_sync_reg <= 2'h0;
        end
        else
        begin
            unlock_sync_reg <= {unlock_sync_reg[0], pll_unlock_i};
            over_sync_reg <= {over_sync_reg[0], adc_overrange_i};
        end
    end

    always_comb
    begin
        cond = 8'h00;
        cond[cmgic_pkg::FLAG_UNLOCK_BIT] = unlock_sync_reg[1];
        cond[cmgic_pkg::FLAG_OVER_BIT] = over_sync_reg[1];
        for (int i = 0; i < 8; i++)
        begin
            case ({mode_msb_reg[i], mode_lsb_reg[i]})
                2'h0: evt[i] = cond[i] && !cond_prev_reg[i];
                2'h1: evt[i] = !cond[i] && cond_prev_reg[i];
                2'h2: evt[i] = cond[i];
                default: evt[i] = 1'b0;
            endcase
        end
        // Set wins over the read clear; masked sources never latch
        flags_next = ((flags_reg & ~(rd_done ? snap_reg : 8'h00)) | evt) & mask_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            flags_reg <= 8'h00;
            cond_prev_reg <= 8'h00;
        end
        else
        begin
            flags_reg <= flags_next;
            cond_prev_reg <= cond;
        end
    end

    assign irq_active = |(flags_reg & mask_reg);

    // Reserved style leaves the pin undriven rather than guess a level
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_pin_o <= 1'b0;
            irq_pin_oe_o <= 1'b1;
        end
        else
        begin
            case (irqctl_reg.style)
                2'h0: {irq_pin_o, irq_pin_oe_o} <= {irq_active, 1'b1};
                2'h1: {irq_pin_o, irq_pin_oe_o} <= {!irq_active, 1'b1};
                2'h2: {irq_pin_o, irq_pin_oe_o} <= {1'b0, irq_active};
                default: {irq_pin_o, irq_pin_oe_o} <= 2'h0;
            endcase
        end
    end

    // Port and filter controls; de-emphasis only under forced lock, 00 means none
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            port_phase_align_o <= 1'b0;
            deemph_select_o <= 2'h0;
            forced_lock_o <= 1'b0;
            pair_volume_link_o <= 3'h0;
        end
        else
        begin
            port_phase_align_o <= irqctl_reg.align;
            deemph_select_o <= forced_lock_reg ? irqctl_reg.deemph : 2'h0;
            forced_lock_o <= forced_lock_reg;
            pair_volume_link_o <= link_reg;
        end
    end

    function automatic cmgic_pkg::cmgic_src_t mix_src(input logic [4:0] code, input logic is_b);
        logic [1:0] sel;
        logic [1:0] other;
        sel = is_b ? code[1:0] : code[3:2];
        other = is_b ? code[3:2] : code[1:0];
        case (sel)
            2'h0: mix_src = cmgic_pkg::SRC_MUTE;
            2'h1: mix_src = cmgic_pkg::SRC_RIGHT;
            2'h2: mix_src = cmgic_pkg::SRC_LEFT;
            default:
            begin
                if (!code[cmgic_pkg::MIX_TOP_BIT])
                    mix_src = cmgic_pkg::SRC_AVG;
                else if (other == (is_b ? 2'h1 : 2'h2))
                    mix_src = cmgic_pkg::SRC_BLAR;
                else
                    mix_src = cmgic_pkg::SRC_ALBR;
            end
        endcase
    endfunction

    // Cross sums carry the half-sum here; the per-output volume is applied downstream
    assign lr_sum = {adc_left_i[23], adc_left_i} + {adc_right_i[23], adc_right_i};

    always_comb
    begin
        for (int c = 0; c < 6; c++)
        begin
            src_c[c] = mix_src(mix_code_reg[c / 2], c[0]);
            case (src_c[c])
                cmgic_pkg::SRC_MUTE: smp_c[c] = '0;
                cmgic_pkg::SRC_RIGHT: smp_c[c] = adc_right_i;
                cmgic_pkg::SRC_LEFT: smp_c[c] = adc_left_i;
                default: smp_c[c] = lr_sum[cmgic_pkg::SAMPLE_W:1];
            endcase
        end
    end

    // Negating full-scale negative wraps; kept to avoid a saturator per channel
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            chan_o <= '0;
        else if (sample_strobe_i)
        begin
            for (int c = 0; c < 6; c++)
            begin
                chan_o[c].src <= src_c[c];
                chan_o[c].sample <= invert_reg[c] ? -smp_c[c] : smp_c[c];
            end
        end
    end

    cmgic_gain_ramp #(
        .TIMEOUT(ZC_TIMEOUT)
    ) u_left_ramp (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .target_i(lgain_reg),
        .ramp_sel_i(ramp_sel_reg),
        .frame_tick_i(sample_strobe_i),
        .zero_cross_i(left_zero_cross_i),
        .level_o(left_gain_level_o)
    );

    cmgic_gain_ramp #(
        .TIMEOUT(ZC_TIMEOUT)
    ) u_right_ramp (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .target_i(rgain_reg),
        .ramp_sel_i(ramp_sel_reg),
        .frame_tick_i(sample_strobe_i),
        .zero_cross_i(right_zero_cross_i),
        .level_o(right_gain_level_o)
    );

    property p_invert;
        @(posedge clk_i) disable iff (sys_rst_i)
        sample_strobe_i && (mix_code_reg[0][3:2] == 2'h2) && invert_reg[0]
            |=> chan_o[0].sample == -$past(adc_left_i);
    endproperty
    a_invert: assert property (p_invert) else $error("channel 0 not inverted");

    property p_mix_reset;
        @(posedge clk_i) $fell(sys_rst_i) |-> (mix_code_reg[1] == 5'h09) && !link_reg[1];
    endproperty
    a_mix_reset: assert property (p_mix_reset) else $error("mix code reset wrong");

    property p_pass_right;
        @(posedge clk_i) disable iff (sys_rst_i)
        sample_strobe_i && (mix_code_reg[2] == 5'h05) && (invert_reg[5:4] == 2'h0)
            |=> chan_o[4].sample == $past(adc_right_i) && chan_o[5].sample == $past(adc_right_i);
    endproperty
    a_pass_right: assert property (p_pass_right) else $error("pair 3 not carrying right");

    property p_cross;
        @(posedge clk_i) disable iff (sys_rst_i)
        sample_strobe_i && (mix_code_reg[0] == 5'h1E)
            |=> chan_o[0].src == cmgic_pkg::SRC_BLAR && chan_o[1].src == cmgic_pkg::SRC_LEFT;
    endproperty
    a_cross: assert property (p_cross) else $error("cross sum decode wrong");

    property p_unlock_flag;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(unlock_sync_reg[1]) && mask_reg[7] && !mode_msb_reg[7] && !mode_lsb_reg[7]
            |=> flags_reg[7] [*2];
    endproperty
    a_unlock_flag: assert property (p_unlock_flag) else $error("unlock flag not held");

    property p_read_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        rd_done && (evt == 8'h00) |=> (flags_reg & $past(snap_reg)) == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

    property p_masked;
        @(posedge clk_i) disable iff (sys_rst_i)
        !mask_reg[1] |=> !flags_reg[1];
    endproperty
    a_masked: assert property (p_masked) else $error("masked flag latched");

    property p_pin_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        (irqctl_reg.style == 2'h1) && irq_active ##1 (irqctl_reg.style == 2'h1)
            |-> !irq_pin_o && irq_pin_oe_o;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("active low pin wrong");

    property p_readback_masked;
        @(posedge clk_i) disable iff (sys_rst_i)
        (bus_st_reg == cmgic_pkg::ST_IDLE) && avs_read_i && (avs_address_i == A_FLAGS)
            |=> (avs_readdata_o[7:0] & ~$past(mask_reg)) == 8'h00;
    endproperty
    a_readback_masked: assert property (p_readback_masked) else $error("masked flag read");

    c_flag_read: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_done && (snap_reg != 8'h00));
    c_cross_mix: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        sample_strobe_i && src_c[0] == cmgic_pkg::SRC_ALBR);
    c_open_drain: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_pin_oe_o && irqctl_reg.style == 2'h2);
endmodule

// file: rtl/cmgic_pkg.sv
package cmgic_pkg;
    // Register indices; each register sits at byte address index * 4
    localparam logic [5:0] IDX_INVERT = 6'h17;
    localparam logic [5:0] IDX_MIX1 = 6'h18;
    localparam logic [5:0] IDX_MIX2 = 6'h19;
    localparam logic [5:0] IDX_MIX3 = 6'h1A;
    localparam logic [5:0] IDX_XCTL = 6'h1B;
    localparam logic [5:0] IDX_LGAIN = 6'h1C;
    localparam logic [5:0] IDX_RGAIN = 6'h1D;
    localparam logic [5:0] IDX_IRQCTL = 6'h1E;
    localparam logic [5:0] IDX_FLAGS = 6'h20;
    localparam logic [5:0] IDX_MASK = 6'h21;
    localparam logic [5:0] IDX_MODE_MSB = 6'h22;
    localparam logic [5:0] IDX_MODE_LSB = 6'h23;

    // Field positions and reset values
    localparam int MIX_LINK_BIT = 7;
    localparam int MIX_TOP_BIT = 4;
    localparam int XCTL_RAMP_LSB = 4;
    localparam int XCTL_LOCK_BIT = 0;
    localparam int CTL_ALIGN_BIT = 7;
    localparam int CTL_DEEMPH_LSB = 4;
    localparam int CTL_STYLE_LSB = 2;
    localparam int FLAG_UNLOCK_BIT = 7;
    localparam int FLAG_OVER_BIT = 1;
    localparam logic [7:0] FLAG_USED = 8'h82;
    localparam logic [4:0] MIX_CODE_RST = 5'h09;
    localparam logic [7:0] REG_RST = 8'h00;

    // Zero-cross timeout in frames: lower bound of the allowed window
    localparam int ZC_TIMEOUT_FRAMES = 512;
    localparam int SAMPLE_W = 24;
    localparam int GAIN_W = 6;
    localparam int LEVEL_W = 9;

    typedef enum logic [2:0] {
        SRC_MUTE = 3'h0,
        SRC_RIGHT = 3'h1,
        SRC_LEFT = 3'h2,
        SRC_AVG = 3'h3,
        SRC_ALBR = 3'h4,
        SRC_BLAR = 3'h5
    } cmgic_src_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACK = 2'h1
    } cmgic_bus_st_t;

    typedef struct packed {
        logic align;
        logic [1:0] deemph;
        logic [1:0] style;
    } cmgic_irqctl_t;

    typedef struct packed {
        cmgic_src_t src;
        logic signed [SAMPLE_W-1:0] sample;
    } cmgic_chan_t;
endpackage

// file: rtl/cmgic_gain_ramp.sv
`timescale 1ns/1ps
module cmgic_gain_ramp #(
    parameter int TIMEOUT = cmgic_pkg::ZC_TIMEOUT_FRAMES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic signed [cmgic_pkg::GAIN_W-1:0] target_i,
    input wire logic [1:0] ramp_sel_i,
    input wire logic frame_tick_i,
    input wire logic zero_cross_i,
    output logic signed [cmgic_pkg::LEVEL_W-1:0] level_o
);
    // Level is held in 1/8 dB units so the soft ramp can step finely
    logic signed [cmgic_pkg::LEVEL_W-1:0] target8;
    logic [9:0] timer_reg;
    logic timeout;
    logic zc_event;
    logic differs;

    assign target8 = {target_i, 3'h0};
    assign differs = (level_o != target8);
    assign timeout = frame_tick_i && (timer_reg == 10'(TIMEOUT - 1));
    assign zc_event = differs && (zero_cross_i || timeout);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            level_o <= '0;
        else
        begin
            case (ramp_sel_i)
                2'h0: level_o <= target8;
                2'h1:
                begin
                    if (zc_event)
                        level_o <= target8;
                end
                2'h2:
                begin
                    if (frame_tick_i && differs)
                        level_o <= (level_o < target8) ? level_o + 9'sh1 : level_o - 9'sh1;
                end
                default:
                begin
                    if (zc_event)
                        level_o <= (level_o < target8) ? level_o + 9'sh1 : level_o - 9'sh1;
                end
            endcase
        end
    end

    // Timer restarts whenever a zero-cross or timeout step lands, bounding the wait for a crossing
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !differs || zc_event)
            timer_reg <= '0;
        else if (frame_tick_i)
            timer_reg <= timer_reg + 10'h1;
    end

    property p_soft_step;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ramp_sel_i == 2'h2) && frame_tick_i && (level_o < target8)
            |=> level_o == $past(level_o) + 9'sh1;
    endproperty
    a_soft_step: assert property (p_soft_step) else $error("soft ramp step wrong");

    property p_soft_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ramp_sel_i == 2'h2) && !frame_tick_i |=> $stable(level_o);
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("level moved between frames");

    c_ramp_done: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        (ramp_sel_i == 2'h2) && $changed(level_o) && !differs);
endmodule

// file: verif/cmgic_src_model.sv
`timescale 1ns/1ps
module cmgic_src_model (
    input wire logic clk_i,
    input wire logic event_i,
    output logic strobe_o = 1'b0,
    output logic unlock_o = 1'b0,
    output logic over_o = 1'b0
);
    logic [2:0] div_reg = 3'h0;
    // One frame tick every 8 clocks keeps ramps short
    always_ff @(posedge clk_i)
    begin
        div_reg <= div_reg + 3'h1;
        strobe_o <= (div_reg == 3'h7);
        unlock_o <= event_i;
        over_o <= event_i;
    end
endmodule

// file: verif/tb_cmgic_top.sv
`timescale 1ns/1ps
module tb_cmgic_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] a = 8'h00;
    logic r = 1'b0;
    logic w = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic wt, ev = 1'b0, stb, unl, ovr, aln, lck, pin, oe;
    logic zc = 1'b0;
    logic [3:0] be = 4'hF;
    logic [1:0] de;
    logic [2:0] lnk;
    logic signed [8:0] lg, rg;
    cmgic_pkg::cmgic_chan_t [5:0] ch;
    int miscompares = 0;
    int compares = 0;
    logic [7:0] d;
    logic [4:0] cd [7] = '{5'h0A, 5'h05, 5'h0F, 5'h00, 5'h1F, 5'h17, 5'h1E};
    logic [2:0] ea [7] = '{3'h2, 3'h1, 3'h3, 3'h0, 3'h4, 3'h1, 3'h5};
    logic [2:0] eb [7] = '{3'h2, 3'h1, 3'h3, 3'h0, 3'h4, 3'h5, 3'h2};
    initial forever #4 clk_i = ~clk_i;
    cmgic_top #(.ZC_TIMEOUT(4)) u_cmgic_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(a), .avs_read_i(r), .avs_write_i(w), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .adc_left_i(24'h000064), .adc_right_i(24'hFFFFD8), .sample_strobe_i(stb),
        .left_zero_cross_i(zc), .right_zero_cross_i(1'b0), .pll_unlock_i(unl),
        .adc_overrange_i(ovr), .chan_o(ch), .pair_volume_link_o(lnk),
        .left_gain_level_o(lg), .right_gain_level_o(rg), .port_phase_align_o(aln),
        .deemph_select_o(de), .forced_lock_o(lck), .irq_pin_o(pin), .irq_pin_oe_o(oe));
    cmgic_src_model u_cmgic_src_model (.clk_i(clk_i), .event_i(ev), .strobe_o(stb),
        .unlock_o(unl), .over_o(ovr));
    task print_verdict;
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Request holds until the rising edge that sees waitrequest low; data is taken there
    task bus(input logic wr, input logic [5:0] i, input logic [7:0] v);
        @(posedge clk_i);
        a <= {i, 2'b00};
        r <= !wr;
        w <= wr;
        wd <= {24'h0, v};
        @(posedge clk_i);
        while (wt !== 1'b0) @(posedge clk_i);
        d = rdata[7:0];
        r <= 1'b0;
        w <= 1'b0;
    endtask
    task rdc(input logic [5:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        chk(d, e);
    endtask
    task pulse;
        ev <= 1'b1;
        repeat (10) @(posedge clk_i);
        ev <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdc(cmgic_pkg::IDX_MIX1, 8'h09);
        rdc(cmgic_pkg::IDX_MASK, 8'h00);
        rdc(cmgic_pkg::IDX_IRQCTL, 8'h00);
        chk({pin, oe}, 2'b01);
        bus(1'b1, cmgic_pkg::IDX_INVERT, 8'hFF);
        rdc(cmgic_pkg::IDX_INVERT, 8'h3F);
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, cmgic_pkg::IDX_MIX1, {3'h0, cd[k]});
            repeat (20) @(posedge clk_i);
            chk(ch[0].src, ea[k]);
            chk(ch[1].src, eb[k]);
        end
        chk($unsigned(ch[1].sample), 24'hFFFF9C);
        bus(1'b1, cmgic_pkg::IDX_INVERT, 8'h00);
        repeat (20) @(posedge clk_i);
        chk(ch[1].sample, 24'h000064);
        be <= 4'hE;
        bus(1'b1, cmgic_pkg::IDX_INVERT, 8'h3F);
        be <= 4'hF;
        rdc(cmgic_pkg::IDX_INVERT, 8'h00);
        bus(1'b1, cmgic_pkg::IDX_MIX2, 8'h80);
        bus(1'b1, cmgic_pkg::IDX_MIX3, 8'h05);
        rdc(cmgic_pkg::IDX_MIX2, 8'h80);
        repeat (20) @(posedge clk_i);
        chk(lnk, 3'h2);
        chk({ch[4].src, ch[5].src}, 6'h09);
        bus(1'b1, cmgic_pkg::IDX_LGAIN, 8'h31);
        bus(1'b1, cmgic_pkg::IDX_RGAIN, 8'h3B);
        repeat (20) @(posedge clk_i);
        chk($unsigned(lg), 9'h188);
        chk($unsigned(rg), 9'h1D8);
        bus(1'b1, cmgic_pkg::IDX_XCTL, 8'h20);
        bus(1'b1, cmgic_pkg::IDX_LGAIN, 8'h0F);
        repeat (16) @(posedge clk_i);
        chk(lg == 9'h078, 1'b0);
        repeat (2100) @(posedge clk_i);
        chk(lg, 9'h078);
        bus(1'b1, cmgic_pkg::IDX_XCTL, 8'h10);
        bus(1'b1, cmgic_pkg::IDX_LGAIN, 8'h05);
        repeat (2) @(posedge clk_i);
        chk(lg, 9'h078);
        zc <= 1'b1;
        @(posedge clk_i);
        zc <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(lg, 9'h028);
        bus(1'b1, cmgic_pkg::IDX_LGAIN, 8'h00);
        repeat (48) @(posedge clk_i);
        chk(lg, 9'h000);
        bus(1'b1, cmgic_pkg::IDX_IRQCTL, 8'hB0);
        repeat (4) @(posedge clk_i);
        chk({aln, de}, 3'h4);
        bus(1'b1, cmgic_pkg::IDX_XCTL, 8'h21);
        repeat (4) @(posedge clk_i);
        chk({lck, de}, 3'h7);
        bus(1'b1, cmgic_pkg::IDX_IRQCTL, 8'h04);
        repeat (4) @(posedge clk_i);
        chk({pin, oe}, 2'b11);
        bus(1'b1, cmgic_pkg::IDX_IRQCTL, 8'h08);
        repeat (4) @(posedge clk_i);
        chk(oe, 1'b0);
        bus(1'b1, cmgic_pkg::IDX_IRQCTL, 8'h00);
        pulse;
        rdc(cmgic_pkg::IDX_FLAGS, 8'h00);
        bus(1'b1, cmgic_pkg::IDX_MASK, 8'hFF);
        rdc(cmgic_pkg::IDX_MASK, 8'h82);
        pulse;
        chk(pin, 1'b1);
        bus(1'b1, cmgic_pkg::IDX_IRQCTL, 8'h04);
        repeat (4) @(posedge clk_i);
        chk({pin, oe}, 2'b01);
        bus(1'b1, cmgic_pkg::IDX_IRQCTL, 8'h08);
        repeat (4) @(posedge clk_i);
        chk({pin, oe}, 2'b01);
        rdc(cmgic_pkg::IDX_FLAGS, 8'h82);
        rdc(cmgic_pkg::IDX_FLAGS, 8'h00);
        repeat (4) @(posedge clk_i);
        chk(oe, 1'b0);
        bus(1'b1, cmgic_pkg::IDX_MODE_LSB, 8'hFF);
        ev <= 1'b1;
        repeat (10) @(posedge clk_i);
        rdc(cmgic_pkg::IDX_FLAGS, 8'h00);
        ev <= 1'b0;
        repeat (10) @(posedge clk_i);
        rdc(cmgic_pkg::IDX_FLAGS, 8'h82);
        print_verdict;
    end
endmodule
